// ---- inc/mic_pkg.sv ----
// Purpose: Shared constants and types for the interrupt controller
// Assumes: 8-bit register port, 125 MHz clock, 3-bit register index
// Notes: Offsets are byte indices on the plain register port
package mic_pkg;
    localparam int ADDR_W = 3;
    localparam int REG_W = 8;
    localparam int PC_W = 13;

    localparam logic [2:0] OFF_IRQ_CONTROL = 3'h0;
    localparam logic [2:0] OFF_FLAGS_1 = 3'h1;
    localparam logic [2:0] OFF_FLAGS_2 = 3'h2;
    localparam logic [2:0] OFF_ENABLE_1 = 3'h3;
    localparam logic [2:0] OFF_ENABLE_2 = 3'h4;
    localparam logic [2:0] OFF_OPTION = 3'h5;
    localparam logic [2:0] OFF_STATUS = 3'h6;

    // irq_control field positions
    localparam int GLB_EN_BIT = 7;
    localparam int PEIE_BIT = 6;
    localparam int TIMER0_EN_BIT = 5;
    localparam int EXTE_BIT = 4;
    localparam int PCHE_BIT = 3;
    localparam int TIMER0_FLAG_BIT = 2;
    localparam int EXTF_BIT = 1;
    localparam int PCHF_BIT = 0;
    // option register
    localparam int EDGE_SEL_BIT = 6;
    // status register
    localparam int ST_ASLEEP_BIT = 0;
    localparam int ST_REQ_BIT = 1;
    localparam int ST_BUSY_BIT = 2;
    // flags_1 / enable_1: parallel port sits at the top bit
    localparam int PSP_BIT = 7;

    localparam logic [7:0] RST_IRQ_CONTROL = 8'h00;
    localparam logic [7:0] RST_PERIPH = 8'h00;
    localparam logic [7:0] RST_OPTION = 8'hFF;
    localparam logic [7:0] FLAGS_2_MASK = 8'h89;
    localparam logic [7:0] TIMER0_MAX = 8'hFF;
    localparam logic [7:0] TIMER0_ZERO = 8'h00;

    localparam logic [12:0] IRQ_VECTOR = 13'h0004;
    localparam logic [1:0] LATENCY_TICKS = 2'h3;
    localparam int INSTR_DIV = 4;

    typedef struct packed {
        logic parallel_port_flag;
        logic converter_done_flag;
        logic serial_rx_flag;
        logic serial_tx_flag;
        logic sync_serial_flag;
        logic capture_compare_a_flag;
        logic timer2_match_flag;
        logic timer1_overflow_flag;
        logic low_voltage_flag;
        logic bus_collision_flag;
        logic capture_compare_b_flag;
    } mic_periph_ev_t;

    typedef struct packed {
        logic vector_load;
        logic push_pc;
        logic [12:0] vector_addr;
    } mic_core_cmd_t;

    typedef enum logic [2:0] {
        ST_RUN = 3'b001,
        ST_COUNT = 3'b010,
        ST_SLEEP = 3'b100
    } mic_state_t;
endpackage

// ---- rtl/mic_pin_sync.sv ----
// Purpose: Three-stage pin synchroniser with agreement filter
// Assumes: Inputs asynchronous to i_clk
// Notes: Accepted level moves only when stages two and three agree
`timescale 1ns/1ns
module mic_pin_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic [WIDTH-1:0] i_pin,
    output logic [WIDTH-1:0] o_level
);
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;
    logic [WIDTH-1:0] agree;

    // Per-bit agreement, first stage is never looked at here
    assign agree = ~(stage2 ^ stage3);

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            meta <= RST_VAL;
            stage2 <= RST_VAL;
            stage3 <= RST_VAL;
            o_level <= RST_VAL;
        end else begin
            meta <= i_pin;
            stage2 <= meta;
            stage3 <= stage2;
            o_level <= (agree & stage3) | (~agree & o_level);
        end
    end
endmodule

// ---- rtl/mic_irq_ctrl.sv ----
// Purpose: Interrupt flags, masks, vectoring and sleep wake-up of an 8-bit core
// Assumes: Core sequencer obeys vector_load/push_pc; peripherals pulse events
// Notes: Instruction cycle is an internal enable every INSTR_DIV clocks
//
// Chosen here: strobed register access and the address map.
`timescale 1ns/1ns

// Overview of operation
// - Flags set on their event regardless of any enable bit.
// - Global enable, control bit 7, passes unmasked sources or blocks all.
// - Global enable plus flagged enabled source starts interrupt entry after three instruction ticks.
// - Every reset clears the global enable.
// - Entry clears global enable, pushes return address, loads PC with 0004h.
// - Return-from-interrupt instruction sets the global enable again.
// - Peripheral flags/enables in two register pairs, gated by group enable.
// - Each source has its own enable bit.
// - Pin and port-change latency three or four instruction cycles.
// - External pin edge: rising if option bit 6 set, else falling.
// - Valid pin edge sets control bit 1.
// - Control bit 4 masks the pin interrupt.
// - Enabled pin interrupt wakes from sleep; global enable decides vectoring.
// - Timer0 rollover FFh to 00h sets bit 2; bit 5 enables.
// - Port B 7:4 change sets bit 0; enable placed at bit 3.
// - Entry saves only the return PC; software saves other context.
// - Up to 14 sources; parallel port absent on small variant.
// - Enabled flagged source wakes sleep whatever the global enable.
// - After wake, next instruction runs, then vector if global enable set.
module mic_irq_ctrl #(
    parameter bit HAS_PARALLEL_PORT = 1'b1,
    parameter int DIV = mic_pkg::INSTR_DIV
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic [mic_pkg::ADDR_W-1:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    input wire logic i_ext_irq_pin,
    input wire logic [3:0] i_port_b_pins,
    input wire logic [7:0] i_timer0_count,
    input wire mic_pkg::mic_periph_ev_t i_periph_ev,
    input wire logic i_return_from_irq_instr,
    input wire logic i_sleep_instr,
    output logic o_irq_req,
    output mic_pkg::mic_core_cmd_t o_core_cmd,
    output logic o_wake,
    output logic o_asleep,
    output logic o_instr_tick
);
    // Set-wins merge of a software write with hardware events
    function automatic logic [7:0] merge_flags(input logic [7:0] cur, input logic wr,
                                               input logic [7:0] wd, input logic [7:0] ev);
        merge_flags = (wr ? wd : cur) | ev;
    endfunction

    function automatic logic any_pending(input logic [7:0] f, input logic [7:0] e);
        any_pending = |(f & e);
    endfunction

    localparam logic [7:0] FLAGS_1_MASK = HAS_PARALLEL_PORT ? 8'hFF : 8'h7F;
    localparam logic [$clog2(DIV)-1:0] DIV_LAST = ($clog2(DIV))'(DIV - 1);

    logic [7:0] irq_control;
    logic [7:0] flags_1;
    logic [7:0] flags_2;
    logic [7:0] enable_1;
    logic [7:0] enable_2;
    logic [7:0] option_reg;
    logic [$clog2(DIV)-1:0] div_cnt;
    logic [1:0] lat_cnt;
    logic [7:0] timer0_prev;
    logic ext_prev;
    logic [3:0] port_prev;
    mic_pkg::mic_state_t state;
    mic_pkg::mic_state_t next_state;

    logic ext_level;
    logic [3:0] port_level;

    mic_pin_sync #(.WIDTH(1), .RST_VAL(1'b0)) u_ext_sync (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_pin(i_ext_irq_pin),
        .o_level(ext_level)
    );

    mic_pin_sync #(.WIDTH(4), .RST_VAL(4'h0)) u_port_sync (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_pin(i_port_b_pins),
        .o_level(port_level)
    );

    // Register strobes
    wire wr_ctl = i_wr && (i_addr == mic_pkg::OFF_IRQ_CONTROL);
    wire wr_f1 = i_wr && (i_addr == mic_pkg::OFF_FLAGS_1);
    wire wr_f2 = i_wr && (i_addr == mic_pkg::OFF_FLAGS_2);
    wire wr_e1 = i_wr && (i_addr == mic_pkg::OFF_ENABLE_1);
    wire wr_e2 = i_wr && (i_addr == mic_pkg::OFF_ENABLE_2);
    wire wr_opt = i_wr && (i_addr == mic_pkg::OFF_OPTION);

    wire tick = (div_cnt == DIV_LAST);
    wire glb_en = irq_control[mic_pkg::GLB_EN_BIT];
    wire peie = irq_control[mic_pkg::PEIE_BIT];
    wire edge_rise = option_reg[mic_pkg::EDGE_SEL_BIT];

    // Source events
    wire ext_event = edge_rise ? (ext_level && !ext_prev)
                               : (!ext_level && ext_prev);
    wire port_event = |(port_level ^ port_prev);
    wire t0_event = (timer0_prev == mic_pkg::TIMER0_MAX)
                 && (i_timer0_count == mic_pkg::TIMER0_ZERO);

    wire [7:0] ctl_ev = {5'h00, t0_event, ext_event, port_event};
    wire [7:0] f1_ev = {i_periph_ev.parallel_port_flag, i_periph_ev.converter_done_flag,
                        i_periph_ev.serial_rx_flag, i_periph_ev.serial_tx_flag,
                        i_periph_ev.sync_serial_flag, i_periph_ev.capture_compare_a_flag,
                        i_periph_ev.timer2_match_flag, i_periph_ev.timer1_overflow_flag};
    wire [7:0] f2_ev = {i_periph_ev.low_voltage_flag, 3'h0,
                        i_periph_ev.bus_collision_flag, 2'h0,
                        i_periph_ev.capture_compare_b_flag};

    // Per-source masking in control byte: enables sit 3 bits above flags
    wire [7:0] ctl_en = {5'h00, irq_control[mic_pkg::TIMER0_EN_BIT],
                         irq_control[mic_pkg::EXTE_BIT],
                         irq_control[mic_pkg::PCHE_BIT]};
    wire core_pend = any_pending(irq_control, ctl_en);
    wire per_pend = peie && (any_pending(flags_1, enable_1)
                          || any_pending(flags_2, enable_2));
    wire pending = core_pend || per_pend;

    // Only a PC push is requested; no other context is saved in hardware
    wire accept = (state == mic_pkg::ST_COUNT) && tick
               && (lat_cnt == mic_pkg::LATENCY_TICKS - 2'h1) && glb_en && pending;

    // Next register values
    logic [7:0] next_control;
    logic [7:0] next_f1;
    logic [7:0] next_f2;
    logic next_glb_en;

    always_comb begin
        next_control = merge_flags(irq_control, wr_ctl, i_wdata, ctl_ev);
        next_f1 = merge_flags(flags_1, wr_f1, i_wdata, f1_ev) & FLAGS_1_MASK;
        next_f2 = merge_flags(flags_2, wr_f2, i_wdata, f2_ev)
                & mic_pkg::FLAGS_2_MASK;
        // Entry clear beats a same-cycle return or software set
        if (accept) begin
            next_glb_en = 1'b0;
        end else if (i_return_from_irq_instr) begin
            next_glb_en = 1'b1;
        end else begin
            next_glb_en = next_control[mic_pkg::GLB_EN_BIT];
        end
        next_control[mic_pkg::GLB_EN_BIT] = next_glb_en;
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            irq_control <= mic_pkg::RST_IRQ_CONTROL;
            flags_1 <= mic_pkg::RST_PERIPH;
            flags_2 <= mic_pkg::RST_PERIPH;
            enable_1 <= mic_pkg::RST_PERIPH;
            enable_2 <= mic_pkg::RST_PERIPH;
            option_reg <= mic_pkg::RST_OPTION;
        end else begin
            irq_control <= next_control;
            flags_1 <= next_f1;
            flags_2 <= next_f2;
            if (wr_e1) begin
                enable_1 <= i_wdata & FLAGS_1_MASK;
            end
            if (wr_e2) begin
                enable_2 <= i_wdata & mic_pkg::FLAGS_2_MASK;
            end
            if (wr_opt) begin
                option_reg <= i_wdata;
            end
        end
    end

    // Edge and rollover history
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            ext_prev <= 1'b0;
            port_prev <= 4'h0;
            timer0_prev <= 8'h00;
        end else begin
            ext_prev <= ext_level;
            port_prev <= port_level;
            timer0_prev <= i_timer0_count;
        end
    end

    // Instruction cycle enable
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            div_cnt <= '0;
        end else if (tick) begin
            div_cnt <= '0;
        end else begin
            div_cnt <= div_cnt + 1'b1;
        end
    end

    // Sleep and wake use enables only, never the global enable
    wire wake_cond = pending;

    always_comb begin
        next_state = state;
        unique case (state)
            mic_pkg::ST_RUN: begin
                // Sleep with a wake source already set completes as a no-op
                if (i_sleep_instr && !wake_cond) begin
                    next_state = mic_pkg::ST_SLEEP;
                end else if (glb_en && pending) begin
                    next_state = mic_pkg::ST_COUNT;
                end
            end
            mic_pkg::ST_COUNT: begin
                // A cleared global enable or flag abandons entry
                if (accept || !glb_en || !pending) begin
                    next_state = mic_pkg::ST_RUN;
                end
            end
            mic_pkg::ST_SLEEP: begin
                if (wake_cond) begin
                    next_state = mic_pkg::ST_RUN;
                end
            end
            default: begin
                next_state = mic_pkg::ST_RUN;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            state <= mic_pkg::ST_RUN;
        end else begin
            state <= next_state;
        end
    end

    // Fixed tick count hides one- versus two-cycle instruction length
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            lat_cnt <= 2'h0;
        end else if (state != mic_pkg::ST_COUNT) begin
            lat_cnt <= 2'h0;
        end else if (tick) begin
            lat_cnt <= lat_cnt + 2'h1;
        end
    end

    // Core command and wake pulse come from flops
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_core_cmd <= '0;
            o_wake <= 1'b0;
        end else begin
            o_core_cmd.vector_load <= accept;
            o_core_cmd.push_pc <= accept;
            o_core_cmd.vector_addr <= mic_pkg::IRQ_VECTOR;
            o_wake <= (state == mic_pkg::ST_SLEEP) && wake_cond;
        end
    end

    // Read mux, unmapped offsets read zero
    wire [7:0] status_val = {5'h00, (state == mic_pkg::ST_COUNT), pending,
                             (state == mic_pkg::ST_SLEEP)};
    logic [7:0] rd_mux;
    always_comb begin
        unique case (i_addr)
            mic_pkg::OFF_IRQ_CONTROL: rd_mux = irq_control;
            mic_pkg::OFF_FLAGS_1: rd_mux = flags_1;
            mic_pkg::OFF_FLAGS_2: rd_mux = flags_2;
            mic_pkg::OFF_ENABLE_1: rd_mux = enable_1;
            mic_pkg::OFF_ENABLE_2: rd_mux = enable_2;
            mic_pkg::OFF_OPTION: rd_mux = option_reg;
            mic_pkg::OFF_STATUS: rd_mux = status_val;
            default: rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_rdata <= 8'h00;
        end else if (i_rd) begin
            o_rdata <= rd_mux;
        end else begin
            o_rdata <= 8'h00;
        end
    end

    // Flags persist until software clears them, so a serviced source repeats
    assign o_irq_req = glb_en && pending;
    assign o_asleep = (state == mic_pkg::ST_SLEEP);
    assign o_instr_tick = tick;
endmodule

// ---- verification/mic_irq_chk.sv ----
// Purpose: Port checker for the interrupt controller
// Assumes: DIV of 4, so entry needs at least nine clocks of request
// Notes: Bound to the design from tb_top
`timescale 1ns/1ns
module mic_irq_chk (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_rd,
    input wire logic [7:0] o_rdata,
    input wire logic o_irq_req,
    input wire mic_pkg::mic_core_cmd_t o_core_cmd,
    input wire logic o_wake,
    input wire logic o_asleep
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    wire logic vl = o_core_cmd.vector_load;

    a_vec_addr: assert property (vl |-> o_core_cmd.vector_addr == 13'h0004)
        else $error("vector address wrong");
    a_push_pc: assert property (vl |-> o_core_cmd.push_pc)
        else $error("return address not pushed");
    a_load_cause: assert property (vl |-> $past(o_irq_req) && $past(o_irq_req, 8))
        else $error("vector without standing request");
    a_gie_drop: assert property (vl |-> !o_irq_req)
        else $error("request stays after entry");
    a_entry_bound: assert property ($rose(o_irq_req) |-> ##[1:24] (vl || !o_irq_req))
        else $error("entry latency too long");
    a_load_single: assert property (vl |=> !vl)
        else $error("vector load longer than a cycle");
    a_wake_cause: assert property ($fell(o_asleep) |-> o_wake)
        else $error("left sleep without wake");
    a_wake_from: assert property (o_wake |-> $past(o_asleep) && !o_asleep)
        else $error("wake while awake");
    a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
        else $error("read data outside read slot");

    c_entry: cover property (vl);
    c_wake: cover property (o_wake);
    c_req: cover property ($rose(o_irq_req));
endmodule

// ---- verification/mic_core_model.sv ----
// Purpose: Core sequencer stand-in that runs a service routine
// Assumes: Service length chosen per scenario, latched at entry
// Notes: Only the return instruction is issued; context is software's job
`timescale 1ns/1ns
module mic_core_model (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire mic_pkg::mic_core_cmd_t i_cmd,
    input wire logic [7:0] i_svc_len,
    output logic o_return,
    output logic [7:0] o_entries
);
    logic [7:0] cnt;
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            cnt <= 8'h00;
            o_return <= 1'b0;
            o_entries <= 8'h00;
        end else begin
            o_return <= (cnt == 8'h01); // Routine ends with the return instruction
            if (i_cmd.vector_load) begin
                cnt <= i_svc_len; // Core keeps only the pushed PC
                o_entries <= o_entries + 8'h01;
            end else if (cnt != 8'h00) begin
                cnt <= cnt - 8'h01;
            end
        end
    end
endmodule

// ---- verification/tb_top.sv ----
// Purpose: Self-checking bench for the interrupt controller
// Assumes: DIV of 4, pins pass the synchroniser within eight clocks
// Notes: Scenarios run in order; entry counts carry across them
`timescale 1ns/1ns
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin mismatches++; \
    $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module tb_top;
    logic i_clk = 1'b0;
    logic i_rstn = 1'b0;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic pin = 1'b0;
    logic [3:0] pb = 4'h0;
    logic [7:0] t0 = 8'h00;
    mic_pkg::mic_periph_ev_t ev = '0;
    logic sleep = 1'b0;
    logic [7:0] svc = 8'h03;
    logic ret, req, wake, asleep;
    logic tick;
    logic [7:0] ents, rdata;
    mic_pkg::mic_core_cmd_t cmd;
    int mismatches = 0;
    int checked = 0;

    mic_irq_ctrl #(.HAS_PARALLEL_PORT(1'b1), .DIV(4)) DUT (
        .i_clk(i_clk), .i_rstn(i_rstn), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
        .i_rd(rd), .o_rdata(rdata), .i_ext_irq_pin(pin), .i_port_b_pins(pb),
        .i_timer0_count(t0), .i_periph_ev(ev), .i_return_from_irq_instr(ret),
        .i_sleep_instr(sleep), .o_irq_req(req), .o_core_cmd(cmd), .o_wake(wake),
        .o_asleep(asleep), .o_instr_tick(tick));
    mic_core_model u_core (.i_clk(i_clk), .i_rstn(i_rstn), .i_cmd(cmd),
        .i_svc_len(svc), .o_return(ret), .o_entries(ents));

    initial forever #4 i_clk = ~i_clk;

    task automatic print_verdict();
        if (mismatches == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic wreg(input logic [2:0] a, input logic [7:0] d);
        @(posedge i_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge i_clk);
        wr <= 1'b0;
    endtask
    task automatic chk_reg(input logic [2:0] a, input logic [7:0] e);
        @(posedge i_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge i_clk);
        rd <= 1'b0;
        #1;
        `CHK(rdata, e)
    endtask
    // Bounded wait on the vector load (sel 0) or the wake pulse (sel 1)
    task automatic wait_on(input int n, input bit sel);
        repeat (n) begin
            @(posedge i_clk);
            #1;
            if ((sel ? wake : cmd.vector_load) === 1'b1) return;
        end
        mismatches++;
        $display("[FAIL] %0t wait ran out", $time);
        print_verdict();
    endtask

    task automatic t_reset_vals();
        int n = 0;
        for (int i = 0; i < 8; i++) chk_reg(i[2:0], i == 5 ? 8'hFF : 8'h00);
        // Instruction tick must pulse once every divider period
        repeat (8) begin
            @(posedge i_clk);
            #1;
            if (tick === 1'b1) n++;
        end
        `CHK(n, 8 / mic_pkg::INSTR_DIV)
        wreg(3'h6, 8'hFF);
        wreg(3'h7, 8'hFF);
        chk_reg(3'h6, 8'h00);
        chk_reg(3'h7, 8'h00);
    endtask
    task automatic t_flags();
        t0 <= 8'hFE;
        @(posedge i_clk);
        t0 <= 8'hFF;
        chk_reg(3'h0, 8'h00);
        t0 <= 8'h00;
        chk_reg(3'h0, 8'h04);
        pin <= 1'b1;
        repeat (8) @(posedge i_clk);
        chk_reg(3'h0, 8'h06);
        wreg(3'h0, 8'h00);
        chk_reg(3'h0, 8'h00);
        wreg(3'h5, 8'hBF);
        pin <= 1'b0;
        pb <= 4'h8;
        repeat (8) @(posedge i_clk);
        chk_reg(3'h0, 8'h03);
        wreg(3'h0, 8'h00);
        pin <= 1'b1;
        repeat (8) @(posedge i_clk);
        chk_reg(3'h0, 8'h00);
        wreg(3'h5, 8'hFF);
        ev <= '1;
        @(posedge i_clk);
        ev <= '0;
        chk_reg(3'h1, 8'hFF);
        chk_reg(3'h2, 8'h89);
        `CHK(req, 1'b0)
        wreg(3'h1, 8'h00);
        wreg(3'h2, 8'h00);
        chk_reg(3'h1, 8'h00);
    endtask
    task automatic t_group();
        wreg(3'h3, 8'h01);
        wreg(3'h0, 8'h80);
        ev <= 11'h008;
        @(posedge i_clk);
        ev <= '0;
        repeat (2) @(posedge i_clk);
        #1;
        `CHK(req, 1'b0)
        chk_reg(3'h6, 8'h00);
        svc <= 8'h20;
        wreg(3'h0, 8'hC0);
        #1;
        `CHK(req, 1'b1)
        wait_on(30, 1'b0);
        chk_reg(3'h0, 8'h40);
        wreg(3'h1, 8'h00); // Service clears its cause
        repeat (40) @(posedge i_clk);
        chk_reg(3'h0, 8'hC0);
        `CHK(req, 1'b0)
        wreg(3'h0, 8'h00);
        wreg(3'h3, 8'h00);
    endtask
    task automatic t_repeat();
        svc <= 8'h03;
        wreg(3'h0, 8'hA0);
        t0 <= 8'hFF;
        @(posedge i_clk);
        t0 <= 8'h00;
        wait_on(30, 1'b0);
        // Core latches the short routine on this edge, lengthen only after it
        @(posedge i_clk);
        svc <= 8'h20;
        wait_on(30, 1'b0); // Flag left set re-enters
        chk_reg(3'h0, 8'h24);
        wreg(3'h0, 8'h20);
        repeat (40) @(posedge i_clk);
        chk_reg(3'h0, 8'hA0);
        `CHK(ents, 8'h03)
    endtask
    task automatic t_sleep();
        wreg(3'h0, 8'h00);
        pin <= 1'b0;
        repeat (8) @(posedge i_clk);
        wreg(3'h0, 8'h10);
        sleep <= 1'b1;
        @(posedge i_clk);
        sleep <= 1'b0;
        #1;
        `CHK(asleep, 1'b1)
        pin <= 1'b1;
        wait_on(12, 1'b1);
        `CHK(asleep, 1'b0)
        repeat (20) @(posedge i_clk);
        `CHK(ents, 8'h03) // No vector with the enable clear
        chk_reg(3'h0, 8'h12);
        wreg(3'h5, 8'hBF);
        wreg(3'h0, 8'h90);
        sleep <= 1'b1;
        @(posedge i_clk);
        sleep <= 1'b0;
        pin <= 1'b0;
        wait_on(12, 1'b1);
        wait_on(30, 1'b0); // Wake, then vector with global enable set
        chk_reg(3'h0, 8'h12);
        `CHK(ents, 8'h04)
        wreg(3'h0, 8'h90);
        pin <= 1'b0;
        pb <= 4'h0;
        i_rstn <= 1'b0;
        repeat (4) @(posedge i_clk);
        i_rstn <= 1'b1;
        chk_reg(3'h0, 8'h00);
    endtask

    initial begin
        repeat (4) @(posedge i_clk);
        i_rstn <= 1'b1;
        t_reset_vals();
        t_flags();
        t_group();
        t_repeat();
        t_sleep();
        print_verdict();
    end
endmodule

bind mic_irq_ctrl mic_irq_chk u_chk (.i_clk(i_clk), .i_rstn(i_rstn), .i_rd(i_rd),
    .o_rdata(o_rdata), .o_irq_req(o_irq_req), .o_core_cmd(o_core_cmd), .o_wake(o_wake),
    .o_asleep(o_asleep));
